// ==== abr_pkg.sv ====
/*
  Shared constants for the address decode and bit-band router.
  Assumes a single bus clock domain at 25 MHz.
*/
package abr_pkg;
  // ==========================================================
  // address map
  localparam logic [31:0] CODE_BASE    = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
  localparam logic [31:0] ALIAS_BASE   = 32'h2200_0000;
  localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
  localparam logic [31:0] EXTRAM_BASE  = 32'h6000_0000;
  localparam logic [31:0] EXTPER_BASE  = 32'ha000_0000;
  localparam logic [31:0] INTPER_BASE  = 32'he000_0000;
  localparam logic [31:0] PPB_END      = 32'he00f_ffff;
  localparam logic [31:0] ALIAS_END    = 32'h23ff_ffff;
  localparam logic [31:0] BAND_END     = 32'h200f_ffff;
  localparam logic [31:0] EXTMEM_END   = 32'h60ff_ffff;
  localparam int          EXT_ADDR_W   = 24;
  // ==========================================================
  // external port timing
  localparam int          EXT_CYCLES   = 4;
  localparam logic [2:0]  EXT_LAST     = 3'h3;
  localparam int          CLK_MHZ      = 25;
  // ==========================================================
  // targets and access sizes
  typedef enum logic [2:0] {
    ABR_T_CODE, ABR_T_SYS, ABR_T_PPB, ABR_T_EXT, ABR_T_NONE
  } abr_target_e;
  typedef enum logic [1:0] {
    ABR_SZ_BYTE, ABR_SZ_HALF, ABR_SZ_WORD
  } abr_size_e;
endpackage

// ==== abr_ext_port.sv ====
/*
  External memory port: turns one request into a four-cycle memory access
  on 8- or 16-bit memory, sync or async strobing.
  Assumes the router holds the request stable until done.
*/
`timescale 1ns/1ps
module abr_ext_port
  import abr_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic                  write,
  input  wire logic [EXT_ADDR_W-1:0] addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wide16,
  input  wire logic                  sync_mode,
  input  wire logic [15:0]           mem_rdata,
  output logic                       mem_cs,
  output logic                       mem_rd,
  output logic                       mem_wr,
  output logic                       mem_clk_en,
  output logic [EXT_ADDR_W-1:0]      mem_addr,
  output logic [15:0]                mem_wdata,
  output logic                       mem_wdata_oe,
  output logic                       done,
  output logic [15:0]                rdata
);
  typedef struct packed {
    logic                  busy;
    logic [2:0]            cnt;
    logic                  wr;
    logic                  cs;
    logic                  rd;
    logic                  wen;
    logic                  cken;
    logic [EXT_ADDR_W-1:0] a;
    logic [15:0]           d;
    logic                  oe;
    logic                  done;
    logic [15:0]           q;
  } abr_ext_s;

  abr_ext_s st;
  abr_ext_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start) begin
        next_st.busy = 1'b1;
        next_st.cnt  = 3'h0;
        next_st.wr   = write;
        next_st.cs   = 1'b1;
        next_st.a    = addr;
        next_st.d    = wide16 ? wdata : {8'h00, wdata[7:0]};
        next_st.oe   = write;
        next_st.rd   = !write;
        next_st.cken = sync_mode;
      end
    end else begin
      next_st.cnt = st.cnt + 3'h1;
      // async strobe narrowed to the second of four cycles for setup and hold
      next_st.wen = st.wr && !sync_mode && (st.cnt == 3'h0);
      if (st.cnt == EXT_LAST - 3'h1) begin
        next_st.q = wide16 ? mem_rdata : {8'h00, mem_rdata[7:0]};
      end
      if (st.cnt == EXT_LAST) begin
        next_st.busy = 1'b0;
        next_st.cs   = 1'b0;
        next_st.rd   = 1'b0;
        next_st.wen  = 1'b0;
        next_st.oe   = 1'b0;
        next_st.cken = 1'b0;
        next_st.done = 1'b1;
      end
      if (sync_mode && st.wr && st.cnt == 3'h0) next_st.wen = 1'b1;
    end
    if (reset) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign mem_cs       = st.cs;
  assign mem_rd       = st.rd;
  assign mem_wr       = st.wen;
  assign mem_clk_en   = st.cken;
  assign mem_addr     = st.a;
  assign mem_wdata    = st.d;
  assign mem_wdata_oe = st.oe;
  assign done         = st.done;
  assign rdata        = st.q;
endmodule

// ==== abr_router.sv ====
/*
  Address decode and bit-band router: steers core accesses to the code
  buses, system bus, private peripheral bus or external memory port, and
  turns bit-band alias writes into read-modify-write on SRAM words.
  Assumes one outstanding request from the core master at a time and
  targets that answer with a one-cycle ack.
*/
`timescale 1ns/1ps
// Functional notes
// - external access takes four bus clocks
// - external memory may be synchronous or asynchronous, chosen by config
// - only one external memory kind at a time
// - external port has 24 address bits, mapped from 0x60000000
// - external data path is 8 or 16 bits wide
// - instruction fetch from external memory only when 16 bits wide
// - external memory access is never gated by security
// - lowest half gigabyte is code, vectors from address zero
// - alias write sets or clears one SRAM bit from data bit 0
// - alias read returns the bit in bit 0, else zeros
// - 0xE0000000 to 0xE00FFFFF decodes as internal peripherals
// - unaligned word and halfword accesses accepted, may be slower
// - code buses carry only code-range accesses
// - system bus carries SRAM, peripherals, external peripherals and above ppb
// - system bus also takes instruction fetches to SRAM
// - system control and debug registers go to private peripheral bus
module abr_router
  import abr_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  ext_wide16,
  input  wire logic                  ext_sync_mode,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic                  req_fetch,
  input  wire logic [1:0]            req_size,
  input  wire logic [31:0]           req_addr,
  input  wire logic [31:0]           req_wdata,
  output logic                       req_done,
  output logic                       req_error,
  output logic [31:0]                req_rdata,
  output logic                       instruction_code_bus_valid,
  output logic                       data_code_bus_valid,
  output logic                       sys_valid,
  output logic                       ppb_valid,
  output logic                       tgt_write,
  output logic [1:0]                 tgt_size,
  output logic [31:0]                tgt_addr,
  output logic [31:0]                tgt_wdata,
  input  wire logic                  tgt_ack,
  input  wire logic [31:0]           tgt_rdata,
  output logic                       mem_cs,
  output logic                       mem_rd,
  output logic                       mem_wr,
  output logic                       mem_clk_en,
  output logic [EXT_ADDR_W-1:0]      mem_addr,
  output logic [15:0]                mem_wdata,
  output logic                       mem_wdata_oe,
  input  wire logic [15:0]           mem_rdata
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ABR_IDLE, ABR_TGT, ABR_BB_RD, ABR_BB_WR, ABR_EXT_LO, ABR_EXT_HI,
    ABR_RESP
  } abr_state_e;

  typedef struct packed {
    abr_state_e  fsm;
    logic        ic;
    logic        dc;
    logic        sys;
    logic        private_peripheral_bus;
    logic        wr;
    logic [1:0]  sz;
    logic [31:0] a;
    logic [31:0] wd;
    logic [4:0]  bitn;
    logic        bbval;
    logic        bbwr;
    logic        done;
    logic        err;
    logic [31:0] rd;
    logic        xstart;
    logic [1:0]  xleft;
    logic [EXT_ADDR_W-1:0] xa;
    logic [15:0] xd;
  } abr_router_s;

  abr_router_s st;
  abr_router_s next_st;

  logic              ext_done;
  logic [15:0]       ext_rdata;
  abr_target_e       target;
  logic              is_alias;
  logic              is_ext;
  logic              fetch_bad;
  logic [31:0]       bb_word;

  // ==========================================================
  // address decode
  always_comb begin
    is_alias  = (req_addr >= ALIAS_BASE) && (req_addr <= ALIAS_END);
    is_ext    = (req_addr >= EXTRAM_BASE) && (req_addr <= EXTMEM_END);
    fetch_bad = 1'b0;
    if (req_addr < SRAM_BASE) begin
      target = ABR_T_CODE;
    end else if (req_addr < INTPER_BASE) begin
      target = ABR_T_SYS;
      if (req_addr >= EXTRAM_BASE && req_addr < EXTPER_BASE) begin
        // only the mapped window of external ram has a device behind it
        target = is_ext ? ABR_T_EXT : ABR_T_NONE;
      end
      if (req_fetch && req_addr >= PERIPH_BASE) begin
        // no fetches from peripherals; external memory needs 16 bits
        fetch_bad = !(is_ext && ext_wide16);
      end
    end else if (req_addr <= PPB_END) begin
      target = ABR_T_PPB;
    end else begin
      target = ABR_T_SYS;
    end
    if (req_fetch && req_addr >= PERIPH_BASE && req_addr >= INTPER_BASE) begin
      fetch_bad = 1'b1;
    end
  end

  // ==========================================================
  // bit-band: alias word back to SRAM word and bit
  always_comb begin
    // byte offset*32 + bit*4 -> word address and bit number
    bb_word = SRAM_BASE | {12'h000, req_addr[24:7], 2'b00};
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.done   = 1'b0;
    next_st.err    = 1'b0;
    next_st.xstart = 1'b0;
    case (st.fsm)
      ABR_IDLE: begin
        if (req_valid) begin
          next_st.wr = req_write;
          next_st.sz = req_size;
          next_st.a  = req_addr;
          next_st.wd = req_wdata;
          if (fetch_bad || target == ABR_T_NONE) begin
            next_st.fsm = ABR_RESP;
            next_st.err = 1'b1;
            next_st.done = 1'b1;
            next_st.rd  = 32'h0000_0000;
            next_st.fsm = ABR_IDLE;
          end else if (is_alias) begin
            next_st.a    = bb_word;
            next_st.bitn = req_addr[6:2];
            next_st.bbval = req_wdata[0];
            next_st.bbwr = req_write;
            next_st.wr   = 1'b0;
            next_st.sz   = 2'(ABR_SZ_WORD);
            next_st.sys  = 1'b1;
            next_st.fsm  = ABR_BB_RD;
          end else if (target == ABR_T_EXT) begin
            // no security check on this path
            next_st.xleft = (ext_wide16 ? 2'h1 : 2'h3);
            if (req_size == 2'(ABR_SZ_BYTE)) next_st.xleft = 2'h0;
            if (req_size == 2'(ABR_SZ_HALF) && ext_wide16) begin
              next_st.xleft = 2'h0;
            end
            if (req_size == 2'(ABR_SZ_HALF) && !ext_wide16) begin
              next_st.xleft = 2'h1;
            end
            next_st.xa     = req_addr[EXT_ADDR_W-1:0];
            next_st.xd     = req_wdata[15:0];
            next_st.xstart = 1'b1;
            next_st.rd     = 32'h0000_0000;
            next_st.fsm    = ABR_EXT_LO;
          end else begin
            next_st.ic  = (target == ABR_T_CODE) && req_fetch;
            next_st.dc  = (target == ABR_T_CODE) && !req_fetch;
            next_st.sys = (target == ABR_T_SYS);
            next_st.private_peripheral_bus = (target == ABR_T_PPB);
            next_st.fsm = ABR_TGT;
          end
        end
      end
      ABR_TGT: begin
        if (tgt_ack) begin
          {next_st.ic, next_st.dc, next_st.sys, next_st.private_peripheral_bus} = 4'h0;
          next_st.rd   = tgt_rdata;
          next_st.done = 1'b1;
          next_st.fsm  = ABR_IDLE;
        end
      end
      ABR_BB_RD: begin
        // read and write back without leaving the bus: atomic to the core
        if (tgt_ack) begin
          if (st.bbwr) begin
            next_st.wd = tgt_rdata;
            next_st.wd[st.bitn] = st.bbval;
            next_st.wr  = 1'b1;
            next_st.fsm = ABR_BB_WR;
          end else begin
            next_st.sys  = 1'b0;
            next_st.rd   = {31'h0, tgt_rdata[st.bitn]};
            next_st.done = 1'b1;
            next_st.fsm  = ABR_IDLE;
          end
        end
      end
      ABR_BB_WR: begin
        if (tgt_ack) begin
          next_st.sys  = 1'b0;
          next_st.wr   = 1'b0;
          next_st.rd   = 32'h0000_0000;
          next_st.done = 1'b1;
          next_st.fsm  = ABR_IDLE;
        end
      end
      ABR_EXT_LO: begin
        // narrow memory: words and halves split into beats, low first
        if (ext_done) begin
          next_st.rd = ext_wide16 ?
            {ext_rdata, st.rd[31:16]} : {ext_rdata[7:0], st.rd[31:8]};
          if (st.xleft == 2'h0) begin
            next_st.done = 1'b1;
            next_st.fsm  = ABR_EXT_HI;
          end else begin
            next_st.xleft  = st.xleft - 2'h1;
            next_st.xa     = st.xa + (ext_wide16 ? 24'h2 : 24'h1);
            next_st.wd     = ext_wide16 ? {16'h0, st.wd[31:16]}
                                        : {8'h0, st.wd[31:8]};
            next_st.xd     = ext_wide16 ? st.wd[31:16]
                                        : {8'h0, st.wd[15:8]};
            next_st.xstart = 1'b1;
          end
        end
      end
      ABR_EXT_HI: begin
        // back to idle; assembled read data is left as shifted in, not right-justified
        next_st.fsm = ABR_IDLE;
      end
      ABR_RESP: begin
        next_st.fsm = ABR_IDLE;
      end
      default: begin
        next_st.fsm = ABR_IDLE;
      end
    endcase
    if (reset) begin
      next_st = '0;
      next_st.fsm = ABR_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // ==========================================================
  // external memory port
  abr_ext_port u_ext (
    .mclk         (mclk),
    .reset        (reset),
    .start        (st.xstart),
    .write        (st.wr),
    .addr         (st.xa),
    .wdata        (st.xd),
    .wide16       (ext_wide16),
    .sync_mode    (ext_sync_mode),
    .mem_rdata    (mem_rdata),
    .mem_cs       (mem_cs),
    .mem_rd       (mem_rd),
    .mem_wr       (mem_wr),
    .mem_clk_en   (mem_clk_en),
    .mem_addr     (mem_addr),
    .mem_wdata    (mem_wdata),
    .mem_wdata_oe (mem_wdata_oe),
    .done         (ext_done),
    .rdata        (ext_rdata)
  );

  assign req_done    = st.done;
  assign req_error   = st.err;
  assign req_rdata   = st.rd;
  assign instruction_code_bus_valid = st.ic;
  assign data_code_bus_valid = st.dc;
  assign sys_valid   = st.sys;
  assign ppb_valid   = st.private_peripheral_bus;
  assign tgt_write   = st.wr;
  assign tgt_size    = st.sz;
  assign tgt_addr    = st.a;
  assign tgt_wdata   = st.wd;
endmodule

// ==== abr_props.sv ====
/*
  Port checker for abr_router.
  Assumes one outstanding core request and a single mclk domain.
*/
`timescale 1ns/1ps
module abr_props
  import abr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ext_wide16,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_fetch,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic        req_done,
  input wire logic        req_error,
  input wire logic [31:0] req_rdata,
  input wire logic        instruction_code_bus_valid,
  input wire logic        data_code_bus_valid,
  input wire logic        sys_valid,
  input wire logic        ppb_valid,
  input wire logic        tgt_write,
  input wire logic [31:0] tgt_addr,
  input wire logic [31:0] tgt_wdata,
  input wire logic        tgt_ack,
  input wire logic        ext_sync_mode,
  input wire logic        mem_cs,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        mem_clk_en,
  input wire logic        mem_wdata_oe
);
  // ==========================================================
  // request tracking
  logic        busy;
  logic        c_fe;
  logic        c_wr;
  logic [31:0] c_a;
  logic [31:0] c_wd;
  logic [31:0] off;
  logic [31:0] aw;
  logic        c_ext;
  logic        c_al;
  logic        c_und;
  always_ff @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0;
      c_a  <= 32'h0;
    end else if (req_valid && (!busy || req_done)) begin
      busy <= 1'b1;
      c_a  <= req_addr;
      c_wr <= req_write;
      c_fe <= req_fetch;
      c_wd <= req_wdata;
    end else if (req_done) begin
      busy <= 1'b0;
    end
  end
  assign off   = c_a - ALIAS_BASE;
  assign aw    = SRAM_BASE + {5'h0, off[31:7], 2'h0};
  assign c_ext = c_a >= EXTRAM_BASE && c_a <= EXTMEM_END;
  assign c_al  = c_a >= ALIAS_BASE && c_a <= ALIAS_END;
  assign c_und = c_a > EXTMEM_END && c_a < EXTPER_BASE;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // properties
  sequence s_answer;
    (instruction_code_bus_valid || data_code_bus_valid || sys_valid || ppb_valid) && tgt_ack
      && !c_al;
  endsequence
  sequence s_ok_done;
    req_done && !req_error;
  endsequence
  property p_ext_len; $rose(mem_cs) |-> mem_cs[*4]; endproperty
  property p_wr_pulse; mem_wr |-> mem_cs ##1 !mem_wr; endproperty
  property p_ext_range; $rose(mem_cs) |-> c_ext; endproperty
  property p_fetch8; busy && c_fe && c_ext && !ext_wide16 |-> !mem_cs;
  endproperty
  property p_code;
    instruction_code_bus_valid || data_code_bus_valid |-> tgt_addr < SRAM_BASE
      && instruction_code_bus_valid == c_fe;
  endproperty
  property p_sys;
    sys_valid |-> tgt_addr >= SRAM_BASE
      && (tgt_addr < INTPER_BASE || tgt_addr > PPB_END);
  endproperty
  property p_ppb;
    ppb_valid |-> tgt_addr >= INTPER_BASE && tgt_addr <= PPB_END;
  endproperty
  property p_undec; $rose(busy) && c_und |-> ##[0:3] (req_done && req_error);
  endproperty
  property p_answer; s_answer |=> s_ok_done; endproperty
  property p_alias_adr; sys_valid && c_al |-> tgt_addr == aw; endproperty
  property p_alias_bit;
    sys_valid && tgt_write && c_al |-> tgt_wdata[off[6:2]] == c_wd[0];
  endproperty
  property p_alias_rd;
    s_ok_done and (c_al && !c_wr) |-> req_rdata[31:1] == 31'h0;
  endproperty
  property p_sync_clk; mem_cs |-> mem_clk_en == ext_sync_mode; endproperty
  property p_dir;
    mem_cs |-> mem_wdata_oe != mem_rd && (!mem_wr || mem_wdata_oe);
  endproperty
  a_ext_len: assert property (p_ext_len)
    else $error("external select not held four cycles");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("external write strobe malformed");
  a_ext_range: assert property (p_ext_range)
    else $error("external select outside external window");
  a_fetch8: assert property (p_fetch8)
    else $error("fetch reached 8-bit external memory");
  a_code: assert property (p_code)
    else $error("code bus carried wrong access");
  a_sys: assert property (p_sys)
    else $error("system bus carried wrong address");
  a_ppb: assert property (p_ppb)
    else $error("private bus carried wrong address");
  a_undec: assert property (p_undec)
    else $error("undecoded access not ended by error");
  a_answer: assert property (p_answer)
    else $error("target answer not passed back");
  a_alias_adr: assert property (p_alias_adr)
    else $error("alias word mapped to wrong sram word");
  a_alias_bit: assert property (p_alias_bit)
    else $error("alias write changed wrong bit value");
  a_alias_rd: assert property (p_alias_rd)
    else $error("alias read returned more than one bit");
  a_sync_clk: assert property (p_sync_clk)
    else $error("memory clock enable disagrees with memory kind");
  a_dir: assert property (p_dir)
    else $error("external data direction wrong");
endmodule

bind abr_router abr_props u_props (
  .mclk, .reset, .ext_wide16, .req_valid, .req_write, .req_fetch,
  .req_addr, .req_wdata, .req_done, .req_error, .req_rdata,
  .instruction_code_bus_valid, .data_code_bus_valid, .sys_valid, .ppb_valid, .tgt_write,
  .tgt_addr, .tgt_wdata, .tgt_ack, .mem_cs, .mem_wr, .ext_sync_mode,
  .mem_rd, .mem_clk_en, .mem_wdata_oe
);

// ==== abr_target_model.sv ====
/*
  Far-side model: bus targets answering with tgt_ack, plus an external
  memory. Assumes registered router outputs on mclk.
*/
`timescale 1ns/1ps
module abr_target_model
  import abr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        ext_wide16,
  input  wire logic        any_valid,
  input  wire logic        tgt_write,
  input  wire logic [31:0] tgt_addr,
  input  wire logic [31:0] tgt_wdata,
  output logic             tgt_ack,
  output logic [31:0]      tgt_rdata,
  input  wire logic        mem_cs,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata
);
  logic [31:0] ram [16];
  logic [15:0] emem [256];
  logic [15:0] last;
  logic [1:0]  cnt;
  // released lines show inverted history, never a stale value
  always_comb begin
    if (mem_cs && mem_rd)
      mem_rdata = ext_wide16 ? emem[mem_addr[7:0]]
                             : {~last[15:8], emem[mem_addr[7:0]][7:0]};
    else
      mem_rdata = ~last;
  end
  always @(posedge mclk) begin
    last      <= reset ? 16'h0 : mem_rdata;
    tgt_rdata <= reset ? 32'h0 : ~tgt_rdata;
    if (mem_cs && mem_wr) begin
      if (ext_wide16)
        emem[mem_addr[7:0]] <= mem_wdata;
      else
        emem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
    end
    if (reset || tgt_ack || !any_valid) begin
      tgt_ack <= 1'b0;
      cnt     <= 2'h0;
    end else if (cnt == (slow ? 2'h3 : 2'h0)) begin
      tgt_ack <= 1'b1;
      if (tgt_write)
        ram[tgt_addr[5:2]] <= tgt_wdata;
      else
        tgt_rdata <= ram[tgt_addr[5:2]];
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// ==== abr_router_test.sv ====
/*
  Self-checking bench for abr_router with the far-side model.
  Assumes the checker is attached by bind.
*/
`timescale 1ns/1ps
module abr_router_test;
  import abr_pkg::*;
  logic        mclk, reset, ext_wide16, ext_sync_mode, slow;
  logic        req_valid, req_write, req_fetch, req_done, req_error;
  logic [1:0]  req_size, tgt_size;
  logic [31:0] req_addr, req_wdata, req_rdata, tgt_addr, tgt_wdata;
  logic [31:0] tgt_rdata;
  logic        instruction_code_bus_valid, data_code_bus_valid, sys_valid, ppb_valid;
  logic        tgt_write, tgt_ack, mem_cs, mem_rd, mem_wr, mem_wdata_oe;
  logic        mem_clk_en;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  int          mismatches, n_compared;
  // {fetch, size, expected bus instruction_code_bus/data_code_bus/sys/ppb}
  localparam logic [31:0] RT_A [11] = '{32'h0000_0100, 32'h0000_0100,
    32'h1fff_8000, 32'h2000_0000, 32'h2000_0002, 32'h2000_0001,
    32'h2000_0004, 32'h4000_4000, 32'ha000_0000, 32'he000_e000,
    32'he010_0000};
  localparam logic [6:0] RT_C [11] = '{7'h68, 7'h24, 7'h24, 7'h22,
    7'h22, 7'h12, 7'h62, 7'h22, 7'h22, 7'h21, 7'h22};
  localparam logic [31:0] ER_A [4] = '{32'h7000_0000, 32'h6100_0000,
    32'h4000_0000, 32'he000_e000};

  abr_router uut (.*);
  abr_target_model model (.mclk, .reset, .slow, .ext_wide16,
    .any_valid(instruction_code_bus_valid | data_code_bus_valid | sys_valid | ppb_valid),
    .tgt_write, .tgt_addr, .tgt_wdata, .tgt_ack, .tgt_rdata, .mem_cs,
    .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // entered at an edge; valid is a one-cycle pulse, the rest held
  task automatic access(input logic [31:0] a, input logic w, f,
      input logic [1:0] sz, input logic [31:0] wd,
      output logic [31:0] rd, output logic er, output logic [3:0] bus);
    int n;
    bus = 4'h0;
    n = 0;
    req_valid <= 1'b1;
    req_addr  <= a;
    req_write <= w;
    req_fetch <= f;
    req_size  <= sz;
    req_wdata <= wd;
    @(posedge mclk);
    req_valid <= 1'b0;
    while (req_done !== 1'b1 && n < 300) begin
      @(posedge mclk);
      bus = bus | {instruction_code_bus_valid, data_code_bus_valid, sys_valid, ppb_valid};
      n++;
    end
    if (req_done !== 1'b1) begin
      mismatches++;
      conclude();
    end
    rd = req_rdata;
    er = req_error;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_route;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  bus;
    foreach (RT_A[i]) begin
      access(RT_A[i], 1'b0, RT_C[i][6], RT_C[i][5:4], 32'h0, rd, er, bus);
      check("route bus", {28'h0, bus}, {28'h0, RT_C[i][3:0]});
      check("route error", {31'h0, er}, 32'h0);
    end
  endtask
  task automatic t_errors;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  bus;
    foreach (ER_A[i]) begin
      access(ER_A[i], 1'b0, i > 1, 2'h2, 32'h0, rd, er, bus);
      check("refused error", {31'h0, er}, 32'h1);
      check("refused bus", {28'h0, bus}, 32'h0);
    end
  endtask
  task automatic t_bitband;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  bus;
    slow <= 1'b1;
    access(32'h2000_0000, 1'b1, 1'b0, 2'h2, 32'hf0, rd, er, bus);
    access(32'h2200_000c, 1'b1, 1'b0, 2'h2, 32'hffff_fff1, rd, er, bus);
    access(32'h2200_0010, 1'b1, 1'b0, 2'h2, 32'hffff_fffe, rd, er, bus);
    access(32'h2200_0028, 1'b1, 1'b0, 2'h2, 32'h1, rd, er, bus);
    access(32'h2000_0000, 1'b0, 1'b0, 2'h2, 32'h0, rd, er, bus);
    check("sram word", rd, 32'h4e8);
    access(32'h2200_0014, 1'b0, 1'b0, 2'h2, 32'h0, rd, er, bus);
    check("alias set bit", rd, 32'h1);
    access(32'h2200_0010, 1'b0, 1'b0, 2'h2, 32'h0, rd, er, bus);
    check("alias clear bit", rd, 32'h0);
    slow <= 1'b0;
  endtask
  task automatic t_ext;
    logic [31:0] rd, a;
    logic        er;
    logic [3:0]  bus;
    for (int k = 0; k < 4; k++) begin
      ext_wide16    <= k[1];
      ext_sync_mode <= k[1];
      a = k[0] ? 32'h60ff_fff8 : 32'h6000_0010;
      @(posedge mclk);
      access(a, 1'b1, 1'b0, 2'h2, a ^ 32'h1234_5678, rd, er, bus);
      access(a, 1'b0, 1'b0, 2'h2, 32'h0, rd, er, bus);
      check("external word", rd, a ^ 32'h1234_5678);
      check("external error", {31'h0, er}, 32'h0);
      access(a, 1'b0, 1'b1, 2'h2, 32'h0, rd, er, bus);
      check("external fetch", {31'h0, er}, {31'h0, !k[1]});
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    ext_wide16 = 1'b1;
    ext_sync_mode = 1'b1;
    slow = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_fetch = 1'b0;
    req_size = 2'h2;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_route();
    t_errors();
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("idle after reset", {27'h0, req_done, instruction_code_bus_valid, data_code_bus_valid,
      sys_valid, ppb_valid}, 32'h0);
    t_bitband();
    t_ext();
    conclude();
  end
endmodule
